/* hdl/tomon_consts.svh */
`ifndef TOMON_CONSTS_SVH
`define TOMON_CONSTS_SVH

// Register byte offsets
`define ADDR_W 12
`define OFS_STATUS 12'h754
`define OFS_REPORT 12'h758
`define OFS_COUNTS 12'h75c
`define OFS_TSCTL 12'h760
`define OFS_IRQ_EN 12'h764

// Geometry
`define NUM_QUEUES 4
`define CNT_W 8
`define SEV_W 2
`define EPOCH_W 8

// Reset values
`define RST_COUNT 8'h00
`define RST_STATUS 4'h0
`define RST_IRQ_EN 4'h0
`define RST_REPORT 8'h82
`define RST_INC 22'h00_0001
`define RST_TC 9'h1dd
`define RST_EPOCH 8'h00

// Time-stamp control fields
`define INC_LSB 0
`define INC_W 22
`define TC_LSB 22
`define TC_W 9
`define TSCTL_MASK 32'h7fff_ffff
`define TS_ACC_W 33
`define TS_CMP_LSB 24

// Core time-out in epochs
`define TIMEOUT_EPOCHS 8'h02

`endif

/* hdl/tomon_pkg.sv */
`include "tomon_consts.svh"

package tomon_pkg;
    typedef logic [`CNT_W-1:0] count_t;
    typedef logic [`NUM_QUEUES-1:0] qmask_t;
    typedef logic [`EPOCH_W-1:0] epoch_t;
    typedef logic [`INC_W-1:0] inc_t;
    typedef logic [`TC_W-1:0] epoch_terminal_value_t;
    typedef logic [`TS_ACC_W-1:0] ts_acc_t;
    typedef enum logic [`SEV_W-1:0] {
        SEV_NONE,
        SEV_COR,
        SEV_NONFATAL,
        SEV_FATAL
    } sev_e;
endpackage

/* hdl/discard_if.sv */
`include "tomon_consts.svh"

interface discard_if;
    import tomon_pkg::*;
    qmask_t hit;
    logic clear;
    logic [`CNT_W*`NUM_QUEUES-1:0] counts;
    modport ctrl (
        output hit,
        output clear,
        input counts
    );
    modport store (
        input hit,
        input clear,
        output counts
    );
endinterface

/* hdl/discard_counter.sv */
`include "tomon_consts.svh"

module discard_counter (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Discard events and counts
    discard_if.store link
);
    import tomon_pkg::*;

    genvar q;
    generate
        for (q = 0; q < `NUM_QUEUES; q++) begin : g_q
            count_t cnt_r;
            count_t cnt_nxt;
            count_t base;
            wire at_max;
            // A discard in the clearing cycle leaves one behind
            assign base = link.clear ? `RST_COUNT : cnt_r;
            assign at_max = &base;
            assign cnt_nxt = (link.hit[q] && !at_max) ? count_t'(base + 1'b1) : base;
            always_ff @(posedge i_clk or posedge i_rst) begin
                if (i_rst) begin
                    cnt_r <= `RST_COUNT;
                end else begin
                    cnt_r <= cnt_nxt;
                end
            end
            assign link.counts[q*`CNT_W +: `CNT_W] = cnt_r;
        end
    endgenerate
endmodule

/* hdl/switch_timeout_monitor.sv */
// Operation
// - A posted-queue time-out discard adds one to count bits 7:0.
// - A non-posted-queue time-out discard adds one to count bits 15:8.
// - A completion-queue time-out discard adds one to count bits 23:16.
// - An insertion-queue time-out discard adds one to count bits 31:24.
// - Each discard counter stops at all ones and never wraps.
// - Reading the counts returns them and then zeroes them; reset value is zero.
// - Each cycle but the epoch-end one, which clears it to zero, the time-stamp accumulator grows by the 22-bit increment, reset 0x1.
// - A larger increment shortens the epoch, terminal count x 2**24 / increment cycles rounded up plus one, and the core time-out with it.
// - The 9-bit terminal count in bits 30:22 is compared with accumulator bits 32:24.
// - When those bits reach or pass the terminal count the time-stamp advances.
// - A queued packet is timed out once two epochs have passed since its stamp.
// - The terminal count resets to 0x1dd.
// - Each time-out discard sets its queue's status flag, cleared by writing one.
// - A flag rising from zero reports as none, correctable, nonfatal or fatal per 2-bit field.
`include "tomon_consts.svh"

module switch_timeout_monitor (
    // Clock and reset
    input wire logic I_CLOCK,
    input wire logic I_RST,
    // APB slave
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [`ADDR_W-1:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    input wire logic [3:0] I_PSTRB,
    output logic [31:0] O_PRDATA,
    output logic O_PREADY,
    output logic O_PSLVERR,
    // Queue discard logic
    input wire tomon_pkg::qmask_t I_DISCARD,
    input wire tomon_pkg::qmask_t I_HEAD_VALID,
    input wire logic [`EPOCH_W*`NUM_QUEUES-1:0] I_HEAD_STAMP,
    output tomon_pkg::qmask_t O_HEAD_EXPIRED,
    output tomon_pkg::epoch_t O_EPOCH,
    output logic O_EPOCH_TICK,
    // Error messages towards the root
    output logic O_ERR_COR,
    output logic O_ERR_NONFATAL,
    output logic O_ERR_FATAL,
    // Interrupt
    output logic O_IRQ
);
    import tomon_pkg::*;

    function automatic logic reg_hit(input logic [`ADDR_W-1:0] addr,
                                     input logic [`ADDR_W-1:0] ofs);
        reg_hit = (addr[`ADDR_W-1:2] == ofs[`ADDR_W-1:2]);
    endfunction

    function automatic logic [31:0] merge_strb(input logic [31:0] old,
                                               input logic [31:0] wdata,
                                               input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = wdata[b*8 +: 8];
            end
        end
        merge_strb = res;
    endfunction

    // Register state
    logic pready_r;
    logic pslverr_r;
    logic [31:0] prdata_r;
    qmask_t status_r;
    qmask_t status_nxt;
    qmask_t irq_en_r;
    qmask_t irq_en_nxt;
    logic [`SEV_W*`NUM_QUEUES-1:0] report_r;
    logic [`SEV_W*`NUM_QUEUES-1:0] report_nxt;
    logic [31:0] tsctl_r;
    logic [31:0] tsctl_nxt;
    logic irq_r;

    // Time-stamp state
    ts_acc_t ts_acc_r;
    ts_acc_t ts_acc_nxt;
    epoch_t epoch_r;
    epoch_t epoch_nxt;
    logic epoch_tick_r;

    // Report and expiry state
    logic err_cor_r;
    logic err_nonfatal_r;
    logic err_fatal_r;
    qmask_t expired_r;
    qmask_t expired_nxt;

    discard_if dlink ();

    // Bus phase decode: one wait state, then completion
    wire acc_first;
    wire acc_done;
    wire wr_done;
    wire rd_first;
    assign acc_first = I_PSEL & I_PENABLE & ~pready_r;
    assign acc_done = I_PSEL & I_PENABLE & pready_r;
    assign wr_done = acc_done & I_PWRITE;
    assign rd_first = acc_first & ~I_PWRITE;

    // Address decode
    wire sel_status;
    wire sel_report;
    wire sel_counts;
    wire sel_tsctl;
    wire sel_irq_en;
    wire sel_any;
    assign sel_status = reg_hit(I_PADDR, `OFS_STATUS);
    assign sel_report = reg_hit(I_PADDR, `OFS_REPORT);
    assign sel_counts = reg_hit(I_PADDR, `OFS_COUNTS);
    assign sel_tsctl = reg_hit(I_PADDR, `OFS_TSCTL);
    assign sel_irq_en = reg_hit(I_PADDR, `OFS_IRQ_EN);
    assign sel_any = sel_status | sel_report | sel_counts | sel_tsctl | sel_irq_en;

    // Register words as software sees them; reserved bits read zero
    wire [31:0] rd_status;
    wire [31:0] rd_report;
    wire [31:0] rd_irq_en;
    assign rd_status = {{(32-`NUM_QUEUES){1'b0}}, status_r};
    assign rd_report = {{(32-`SEV_W*`NUM_QUEUES){1'b0}}, report_r};
    assign rd_irq_en = {{(32-`NUM_QUEUES){1'b0}}, irq_en_r};

    // Read selection; unmapped addresses read zero
    wire [31:0] rd_mux;
    assign rd_mux = sel_status ? rd_status :
                    sel_report ? rd_report :
                    sel_counts ? dlink.counts :
                    sel_tsctl ? tsctl_r :
                    sel_irq_en ? rd_irq_en :
                    32'h0000_0000;

    // Write data after byte strobes
    wire [31:0] wr_status;
    wire [31:0] wr_report;
    wire [31:0] wr_tsctl;
    wire [31:0] wr_irq_en;
    assign wr_status = merge_strb(32'h0000_0000, I_PWDATA, I_PSTRB);
    assign wr_report = merge_strb(rd_report, I_PWDATA, I_PSTRB);
    assign wr_tsctl = merge_strb(tsctl_r, I_PWDATA, I_PSTRB) & `TSCTL_MASK;
    assign wr_irq_en = merge_strb(rd_irq_en, I_PWDATA, I_PSTRB);

    // Status flags: a new discard wins over a write-one clear
    wire [`NUM_QUEUES-1:0] status_clr;
    assign status_clr = (wr_done && sel_status) ? wr_status[`NUM_QUEUES-1:0] :
                        {`NUM_QUEUES{1'b0}};
    assign status_nxt = (status_r & ~status_clr) | I_DISCARD;

    assign report_nxt = (wr_done && sel_report) ? wr_report[`SEV_W*`NUM_QUEUES-1:0] :
                        report_r;
    assign tsctl_nxt = (wr_done && sel_tsctl) ? wr_tsctl : tsctl_r;
    assign irq_en_nxt = (wr_done && sel_irq_en) ? wr_irq_en[`NUM_QUEUES-1:0] : irq_en_r;

    // Discard counters, cleared when their read data is captured
    assign dlink.hit = I_DISCARD;
    assign dlink.clear = rd_first & sel_counts;

    discard_counter u_counter (
        .i_clk(I_CLOCK),
        .i_rst(I_RST),
        .link(dlink.store)
    );

    // Time-stamp generator
    wire inc_t ts_inc;
    wire epoch_terminal_value_t ts_tc;
    wire epoch_end;
    assign ts_inc = tsctl_r[`INC_LSB +: `INC_W];
    assign ts_tc = tsctl_r[`TC_LSB +: `TC_W];
    assign epoch_end = (ts_acc_r[`TS_CMP_LSB +: `TC_W] >= ts_tc);
    // Larger increment reaches the terminal count sooner
    assign ts_acc_nxt = epoch_end ? ts_acc_t'(0) :
                        ts_acc_t'(ts_acc_r + ts_acc_t'(ts_inc));
    assign epoch_nxt = epoch_end ? epoch_t'(epoch_r + 1'b1) : epoch_r;

    // Head-of-queue age check against the current time-stamp
    genvar q;
    generate
        for (q = 0; q < `NUM_QUEUES; q++) begin : g_age
            wire epoch_t age;
            assign age = epoch_t'(epoch_r - I_HEAD_STAMP[q*`EPOCH_W +: `EPOCH_W]);
            assign expired_nxt[q] = I_HEAD_VALID[q] & (age >= `TIMEOUT_EPOCHS);
        end
    endgenerate

    // Error reporting on a flag's rising edge
    wire qmask_t flag_rise;
    qmask_t want_cor;
    qmask_t want_nonfatal;
    qmask_t want_fatal;
    assign flag_rise = I_DISCARD & ~status_r;
    generate
        for (q = 0; q < `NUM_QUEUES; q++) begin : g_sev
            wire sev_e sev;
            assign sev = sev_e'(report_r[q*`SEV_W +: `SEV_W]);
            assign want_cor[q] = flag_rise[q] & (sev == SEV_COR);
            assign want_nonfatal[q] = flag_rise[q] & (sev == SEV_NONFATAL);
            assign want_fatal[q] = flag_rise[q] & (sev == SEV_FATAL);
        end
    endgenerate

    // Bus handshake registers
    always_ff @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            pready_r <= acc_first;
            pslverr_r <= acc_first & ~sel_any;
        end
    end

    // Read data capture; holds between reads
    always_ff @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
            prdata_r <= 32'h0000_0000;
        end else if (rd_first) begin
            prdata_r <= rd_mux;
        end
    end

    // Status flags and interrupt; sticky through all but the main reset
    always_ff @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
            status_r <= `RST_STATUS;
            irq_r <= 1'b0;
        end else begin
            status_r <= status_nxt;
            irq_r <= |(status_nxt & irq_en_nxt);
        end
    end

    // Reporting control and interrupt enables
    always_ff @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
            report_r <= `RST_REPORT;
            irq_en_r <= `RST_IRQ_EN;
        end else begin
            report_r <= report_nxt;
            irq_en_r <= irq_en_nxt;
        end
    end

    // Time-stamp control
    always_ff @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
            tsctl_r <= {1'b0, `RST_TC, `RST_INC};
        end else begin
            tsctl_r <= tsctl_nxt;
        end
    end

    // Time-stamp accumulator
    always_ff @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
            ts_acc_r <= ts_acc_t'(0);
        end else begin
            ts_acc_r <= ts_acc_nxt;
        end
    end

    // Epoch count and its tick
    always_ff @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
            epoch_r <= `RST_EPOCH;
            epoch_tick_r <= 1'b0;
        end else begin
            epoch_r <= epoch_nxt;
            epoch_tick_r <= epoch_end;
        end
    end

    // Message pulses
    always_ff @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
            err_cor_r <= 1'b0;
            err_nonfatal_r <= 1'b0;
            err_fatal_r <= 1'b0;
        end else begin
            err_cor_r <= |want_cor;
            err_nonfatal_r <= |want_nonfatal;
            err_fatal_r <= |want_fatal;
        end
    end

    // Head expiry flags
    always_ff @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
            expired_r <= {`NUM_QUEUES{1'b0}};
        end else begin
            expired_r <= expired_nxt;
        end
    end

    // Outputs
    assign O_PRDATA = prdata_r;
    assign O_PREADY = pready_r;
    assign O_PSLVERR = pslverr_r;
    assign O_HEAD_EXPIRED = expired_r;
    assign O_EPOCH = epoch_r;
    assign O_EPOCH_TICK = epoch_tick_r;
    assign O_ERR_COR = err_cor_r;
    assign O_ERR_NONFATAL = err_nonfatal_r;
    assign O_ERR_FATAL = err_fatal_r;
    assign O_IRQ = irq_r;
endmodule

/* tb/tomon_sva.sv */
`include "tomon_consts.svh"

module tomon_sva (
    // Clock and bus
    input wire logic I_CLOCK,
    input wire logic I_RST,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic [`ADDR_W-1:0] I_PADDR,
    input wire logic O_PREADY,
    input wire logic O_PSLVERR,
    input wire logic O_IRQ,
    // Queue side
    input wire tomon_pkg::qmask_t I_DISCARD,
    input wire tomon_pkg::qmask_t I_HEAD_VALID,
    input wire logic [`EPOCH_W*`NUM_QUEUES-1:0] I_HEAD_STAMP,
    input wire tomon_pkg::qmask_t O_HEAD_EXPIRED,
    input wire tomon_pkg::epoch_t O_EPOCH,
    input wire logic O_EPOCH_TICK,
    input wire logic O_ERR_COR,
    input wire logic O_ERR_NONFATAL,
    input wire logic O_ERR_FATAL
);
    import tomon_pkg::*;
    default clocking @(posedge I_CLOCK); endclocking
    default disable iff (I_RST);
    wire logic mapped = I_PADDR[11:2] >= 10'h1d5 && I_PADDR[11:2] <= 10'h1d9;
    wire logic any_err = O_ERR_COR || O_ERR_NONFATAL || O_ERR_FATAL;

    a_tick_step: assert property (O_EPOCH_TICK |-> O_EPOCH == 8'($past(O_EPOCH) + 8'h1))
        else $error("epoch did not step by one on tick");
    a_epoch_hold: assert property (!O_EPOCH_TICK |-> O_EPOCH == $past(O_EPOCH))
        else $error("epoch moved without tick");
    a_err_cause: assert property (any_err |-> $past(|I_DISCARD))
        else $error("error message without discard");
    a_irq_cause: assert property ($rose(O_IRQ) |-> $past(|I_DISCARD) || $past(I_PSEL))
        else $error("interrupt rose without cause");
    a_ready_pulse: assert property (O_PREADY |=> !O_PREADY)
        else $error("ready longer than one cycle");
    a_ready_wait: assert property (I_PSEL && I_PENABLE && !O_PREADY |=> O_PREADY)
        else $error("ready not after first access cycle");
    a_slverr_map: assert property (O_PREADY |-> O_PSLVERR == !mapped)
        else $error("error response does not match decode");
    a_expire_valid: assert property ((O_HEAD_EXPIRED & ~$past(I_HEAD_VALID)) == 4'h0)
        else $error("expiry without queued head");
    a_expire_age: assert property (I_HEAD_VALID[1] && 8'(O_EPOCH - I_HEAD_STAMP[15:8]) < 8'h2
        |=> !O_HEAD_EXPIRED[1])
        else $error("head expired too young");

    c_tick: cover property (O_EPOCH_TICK);
    c_fatal: cover property (O_ERR_FATAL);
    c_slverr: cover property (O_PREADY && O_PSLVERR);
endmodule

bind switch_timeout_monitor tomon_sva u_tomon_sva (.I_CLOCK(I_CLOCK), .I_RST(I_RST),
    .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .I_PADDR(I_PADDR), .O_PREADY(O_PREADY),
    .O_PSLVERR(O_PSLVERR), .O_IRQ(O_IRQ), .I_DISCARD(I_DISCARD), .I_HEAD_VALID(I_HEAD_VALID),
    .I_HEAD_STAMP(I_HEAD_STAMP), .O_HEAD_EXPIRED(O_HEAD_EXPIRED), .O_EPOCH(O_EPOCH),
    .O_EPOCH_TICK(O_EPOCH_TICK), .O_ERR_COR(O_ERR_COR), .O_ERR_NONFATAL(O_ERR_NONFATAL),
    .O_ERR_FATAL(O_ERR_FATAL));

/* tb/queue_model.sv */
module queue_model (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Bench control
    input wire tomon_pkg::qmask_t i_push,
    input wire tomon_pkg::qmask_t i_force,
    // Monitor side
    input wire tomon_pkg::epoch_t i_epoch,
    input wire tomon_pkg::qmask_t i_expired,
    output tomon_pkg::qmask_t o_discard,
    output tomon_pkg::qmask_t o_head_valid,
    output logic [31:0] o_head_stamp
);
    import tomon_pkg::*;
    qmask_t valid_r;
    qmask_t drop_r;
    logic [31:0] stamp_r;
    wire logic [31:0] vmask = {{8{valid_r[3]}}, {8{valid_r[2]}}, {8{valid_r[1]}}, {8{valid_r[0]}}};
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            valid_r <= '0;
            drop_r <= '0;
            stamp_r <= '0;
        end else begin
            // Expired heads leave the queue one cycle later
            drop_r <= valid_r & i_expired;
            valid_r <= (valid_r & ~i_expired) | i_push;
            for (int q = 0; q < 4; q++) begin
                if (i_push[q]) begin
                    stamp_r[8*q+:8] <= i_epoch;
                end
            end
        end
    end
    assign o_discard = drop_r | i_force;
    assign o_head_valid = valid_r;
    // Empty heads show a scrambled stamp
    assign o_head_stamp = stamp_r ^ ~vmask;
endmodule

/* tb/switch_timeout_monitor_test.sv */
`include "tomon_consts.svh"

module switch_timeout_monitor_test;
    timeunit 1ns;
    timeprecision 1ps;
    import tomon_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, hstamp, r;
    logic pready, pslverr, irq, tick, e_cor, e_nf, e_fat, e;
    qmask_t discard, hvalid, expired;
    qmask_t push = 4'h0;
    qmask_t frc = 4'h0;
    epoch_t epoch, st;
    int mismatches = 0;
    int check_count = 0;
    int n;

    switch_timeout_monitor u_switch_timeout_monitor (.I_CLOCK(clk), .I_RST(rst),
        .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr),
        .I_PWDATA(pwdata), .I_PSTRB(4'hf), .O_PRDATA(prdata), .O_PREADY(pready),
        .O_PSLVERR(pslverr), .I_DISCARD(discard), .I_HEAD_VALID(hvalid), .I_HEAD_STAMP(hstamp),
        .O_HEAD_EXPIRED(expired), .O_EPOCH(epoch), .O_EPOCH_TICK(tick), .O_ERR_COR(e_cor),
        .O_ERR_NONFATAL(e_nf), .O_ERR_FATAL(e_fat), .O_IRQ(irq));
    queue_model u_queue_model (.i_clk(clk), .i_rst(rst), .i_push(push), .i_force(frc),
        .i_epoch(epoch), .i_expired(expired), .o_discard(discard), .o_head_valid(hvalid),
        .o_head_stamp(hstamp));

    initial begin
        forever #4 clk = ~clk;
    end

    task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        // Ready, read data and error are taken at the edge that sees ready high
        @(posedge clk);
        while (pready !== 1'b1 && k < 20) begin
            @(posedge clk);
            k++;
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k == 20) begin
            mismatches++;
            summarize();
        end
    endtask

    task automatic rd(input logic [11:0] a, input logic [32:0] x);
        apb(1'b0, a, 32'h0);
        chk({e, r}, x);
    endtask

    // Cycles from one epoch tick to the next
    task automatic gap(output int cnt);
        int k;
        k = 0;
        @(negedge clk);
        while (tick !== 1'b1 && k < 999) begin
            @(negedge clk);
            k++;
        end
        @(negedge clk);
        cnt = 1;
        while (tick !== 1'b1 && cnt < 999) begin
            @(negedge clk);
            cnt++;
        end
        if (k == 999 || cnt == 999) begin
            mismatches++;
            summarize();
        end
    endtask

    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd(`OFS_STATUS, 33'h0);
        rd(`OFS_REPORT, 33'h82);
        rd(`OFS_COUNTS, 33'h0);
        rd(`OFS_TSCTL, 33'h0_7740_0001);
        rd(`OFS_IRQ_EN, 33'h0);
        rd(12'h768, 33'h1_0000_0000);
        $display("test reset done");
        for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            frc <= 4'hf << k;
        end
        @(posedge clk);
        frc <= 4'h0;
        rd(`OFS_COUNTS, 33'h0_0403_0201);
        rd(`OFS_COUNTS, 33'h0);
        rd(`OFS_STATUS, 33'hf);
        @(posedge clk);
        frc <= 4'h1;
        repeat (300) @(posedge clk);
        frc <= 4'h0;
        rd(`OFS_COUNTS, 33'hff);
        $display("test counts done");
        apb(1'b1, `OFS_IRQ_EN, 32'h8);
        @(negedge clk);
        chk(33'(irq), 33'h1);
        apb(1'b1, `OFS_STATUS, 32'h8);
        @(negedge clk);
        chk(33'(irq), 33'h0);
        rd(`OFS_STATUS, 33'h7);
        apb(1'b1, `OFS_STATUS, 32'h7);
        $display("test interrupt done");
        apb(1'b1, `OFS_REPORT, 32'he4);
        // Fifth pass hits a flag that is already set
        for (int q = 0; q < 5; q++) begin
            @(posedge clk);
            frc <= 4'h1 << ((q < 4) ? q : 3);
            @(posedge clk);
            frc <= 4'h0;
            @(negedge clk);
            chk(33'({e_fat, e_nf, e_cor}), 33'((q < 4) ? (1 << q) >> 1 : 0));
        end
        $display("test severity done");
        apb(1'b1, `OFS_TSCTL, 32'h0060_0000);
        rd(`OFS_TSCTL, 33'h0060_0000);
        gap(n);
        chk(33'(n), 33'(2 ** 24 / 32'h20_0000 + 1));
        apb(1'b1, `OFS_TSCTL, 32'h0050_0000);
        gap(n);
        chk(33'(n), 33'(2 ** 24 / 32'h10_0000 + 1));
        $display("test epoch done");
        @(posedge clk);
        push <= 4'h2;
        @(posedge clk);
        push <= 4'h0;
        @(negedge clk);
        st = hstamp[15:8];
        n = 0;
        while (discard[1] !== 1'b1 && n < 200) begin
            @(negedge clk);
            n++;
        end
        chk(33'(8'(epoch - st)), 33'h2);
        chk(33'(n < 200), 33'h1);
        $display("test timeout done");
        summarize();
    end
endmodule
